// ### verilog/gw_pkg.sv
`default_nettype none
package gw_pkg;
  // ****************************************
  // serial link timing
  // ****************************************
  localparam int unsigned CLK_HZ     = 100_000_000;
  localparam int unsigned BAUD_RATE  = 9600;
  localparam int unsigned BIT_CYCLES = CLK_HZ / BAUD_RATE;
  localparam int unsigned DATA_BITS  = 8;
  // ****************************************
  // telegram framing characters
  // ****************************************
  localparam logic [7:0] CHAR_STX = 8'h02;
  localparam logic [7:0] CHAR_CR  = 8'h0d;
  localparam logic [7:0] CHAR_LF  = 8'h0a;
  // ****************************************
  // process images and selector
  // ****************************************
  localparam int unsigned IMG_BYTES     = 16;
  localparam int unsigned LEN_W         = 8;
  localparam int unsigned SEL_W         = 4;
  localparam logic [3:0]  SEL_UNIVERSAL = 4'h0;
  localparam int unsigned FIFO_DEPTH    = 8;
  typedef enum logic [1:0] {ST_INIT, ST_PREOP, ST_SAFEOP, ST_OP} slave_state_t;
endpackage : gw_pkg
`default_nettype wire

// ### verilog/fieldbus_if.sv
`default_nettype none
interface fieldbus_if #(
  parameter int unsigned IMG_BYTES = gw_pkg::IMG_BYTES
);
  import gw_pkg::*;
  logic [IMG_BYTES*8-1:0] out_image;
  logic [LEN_W-1:0]       out_len;
  logic                   send_output_toggle;
  logic                   op_request;
  logic [IMG_BYTES*8-1:0] in_image;
  logic [LEN_W-1:0]       in_len;
  logic                   new_data_toggle;
  slave_state_t           slave_state;
  modport gateway (
    input  out_image, out_len, send_output_toggle, op_request,
    output in_image, in_len, new_data_toggle, slave_state
  );
  modport master (
    output out_image, out_len, send_output_toggle, op_request,
    input  in_image, in_len, new_data_toggle, slave_state
  );
endinterface : fieldbus_if
`default_nettype wire

// ### verilog/serial_gateway.sv
`default_nettype none
module serial_gateway #(
  parameter int unsigned BIT_CYCLES = gw_pkg::BIT_CYCLES,
  parameter int unsigned IMG_BYTES  = gw_pkg::IMG_BYTES
) (
  input  wire logic                     sys_clk_i,
  input  wire logic                     srst_i,
  fieldbus_if.gateway                   fb,
  input  wire logic                     ser_rx_i,
  output logic                          ser_tx_o,
  input  wire logic [gw_pkg::SEL_W-1:0] device_selector_switch_i,
  output logic      [gw_pkg::SEL_W-1:0] profile_o,
  output logic                          frame_err_o
);
  import gw_pkg::*;
  localparam int unsigned CW = $clog2(BIT_CYCLES + 1);
  localparam logic [CW-1:0] BIT_LAST  = CW'(BIT_CYCLES - 1);
  localparam logic [CW-1:0] HALF_LAST = CW'(BIT_CYCLES / 2 - 1);
  localparam int unsigned BUF_BYTES = IMG_BYTES + 1;

  // ****************************************
  // startup: selector and slave state
  // ****************************************
  logic profile_taken;
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      profile_taken <= 1'b0;
      profile_o     <= SEL_UNIVERSAL;
    end else if (!profile_taken) begin
      profile_taken <= 1'b1;
      profile_o     <= device_selector_switch_i;
    end
  end

  // one step per cycle while the master asks; dropping the request falls back to init
  always_ff @(posedge sys_clk_i) begin
    if (srst_i || !fb.op_request || !profile_taken) begin
      fb.slave_state <= ST_INIT;
    end else begin
      unique case (fb.slave_state)
        ST_INIT:   fb.slave_state <= ST_PREOP;
        ST_PREOP:  fb.slave_state <= ST_SAFEOP;
        ST_SAFEOP: fb.slave_state <= ST_OP;
        ST_OP:     fb.slave_state <= ST_OP;
      endcase
    end
  end

  logic online;
  assign online = (fb.slave_state == ST_OP);

  // ****************************************
  // serial receiver
  // ****************************************
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;
  rx_state_t   rx_state;
  logic [CW-1:0] rx_cnt;
  logic [2:0]  rx_bit;
  logic [7:0]  rx_shift;
  logic        rx_valid;
  logic        rx_bad;

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      rx_state <= RX_IDLE;
      rx_cnt   <= '0;
      rx_bit   <= '0;
      rx_shift <= '0;
      rx_valid <= 1'b0;
      rx_bad   <= 1'b0;
    end else begin
      rx_valid <= 1'b0;
      rx_bad   <= 1'b0;
      if (rx_state != RX_IDLE && rx_cnt != '0) begin
        rx_cnt <= rx_cnt - CW'(1);
      end else begin
        unique case (rx_state)
          RX_IDLE: if (!ser_rx_i) begin
            rx_state <= RX_START;
            rx_cnt   <= HALF_LAST;
          end
          RX_START: begin
            rx_state <= ser_rx_i ? RX_IDLE : RX_DATA; // glitch rejected at mid-bit
            rx_cnt   <= BIT_LAST;
            rx_bit   <= '0;
          end
          RX_DATA: begin
            rx_shift <= {ser_rx_i, rx_shift[7:1]};
            rx_bit   <= rx_bit + 3'd1;
            rx_cnt   <= BIT_LAST;
            if (rx_bit == 3'(DATA_BITS - 1)) rx_state <= RX_STOP;
          end
          RX_STOP: begin
            rx_state <= RX_IDLE;
            rx_valid <= ser_rx_i;
            rx_bad   <= !ser_rx_i;
          end
        endcase
      end
    end
  end

  // ****************************************
  // telegram assembly into the input image
  // ****************************************
  logic [BUF_BYTES*8-1:0] tel_buf;
  logic [LEN_W-1:0]       tel_len;
  logic                   in_tel;
  logic                   got_cr;

  // the cr is stored as data until the lf proves it was the terminator
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      tel_buf            <= '0;
      tel_len            <= '0;
      in_tel             <= 1'b0;
      got_cr             <= 1'b0;
      frame_err_o        <= 1'b0;
      fb.in_image        <= '0;
      fb.in_len          <= '0;
      fb.new_data_toggle <= 1'b0;
    end else begin
      frame_err_o <= rx_bad;
      if (rx_valid) begin
        got_cr <= (rx_shift == CHAR_CR);
        if (rx_shift == CHAR_STX) begin
          in_tel  <= 1'b1;
          tel_len <= '0;
        end else if (in_tel && got_cr && rx_shift == CHAR_LF) begin
          in_tel  <= 1'b0;
          tel_len <= '0; // a headerless telegram must start again at byte 0
          if (online) begin
            fb.in_image        <= tel_buf[IMG_BYTES*8-1:0];
            fb.in_len          <= tel_len - LEN_W'(1);
            fb.new_data_toggle <= !fb.new_data_toggle;
          end
        end else if (in_tel || profile_o == SEL_UNIVERSAL) begin
          if (tel_len == LEN_W'(BUF_BYTES)) begin
            in_tel      <= 1'b0; // overlong telegram dropped, not truncated
            frame_err_o <= 1'b1;
            tel_len     <= '0;
          end else begin
            in_tel                  <= 1'b1;
            tel_buf[tel_len*8 +: 8] <= rx_shift;
            tel_len                 <= tel_len + LEN_W'(1);
          end
        end
      end
    end
  end

  // ****************************************
  // send path: toggle, snapshot, framing
  // ****************************************
  typedef enum logic [2:0] {TX_IDLE, TX_HEAD, TX_BODY, TX_CR, TX_LF} load_state_t;
  load_state_t            load_state;
  logic                   sdo_seen;
  logic [IMG_BYTES*8-1:0] snap_image;
  logic [LEN_W-1:0]       snap_len;
  logic [LEN_W-1:0]       snap_idx;
  logic [7:0]             push_data;
  logic                   push_valid;
  logic                   push_ready;

  always_comb begin
    unique case (load_state)
      TX_HEAD: push_data = CHAR_STX;
      TX_BODY: push_data = snap_image[snap_idx*8 +: 8];
      TX_CR:   push_data = CHAR_CR;
      TX_LF:   push_data = CHAR_LF;
      default: push_data = 8'h00;
    endcase
  end
  assign push_valid = (load_state != TX_IDLE);

  // a flip arriving mid-send waits in the mismatch and is served afterwards
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      load_state <= TX_IDLE;
      sdo_seen   <= 1'b0;
      snap_image <= '0;
      snap_len   <= '0;
      snap_idx   <= '0;
    end else if (load_state == TX_IDLE) begin
      if (fb.send_output_toggle != sdo_seen) begin
        sdo_seen <= fb.send_output_toggle;
        if (online) begin
          snap_image <= fb.out_image;
          snap_len   <= (fb.out_len > LEN_W'(IMG_BYTES)) ? LEN_W'(IMG_BYTES) : fb.out_len;
          snap_idx   <= '0;
          load_state <= TX_HEAD;
        end
      end
    end else if (push_ready) begin // fifo full stalls framing
      unique case (load_state)
        TX_HEAD: load_state <= (snap_len == '0) ? TX_CR : TX_BODY;
        TX_BODY: begin
          snap_idx <= snap_idx + LEN_W'(1);
          if (snap_idx + LEN_W'(1) == snap_len) load_state <= TX_CR;
        end
        TX_CR:   load_state <= TX_LF;
        default: load_state <= TX_IDLE;
      endcase
    end
  end

  logic [7:0] pop_data;
  logic       pop_valid;
  logic       tx_busy;

  gw_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) u_tx_fifo (
    .sys_clk_i   (sys_clk_i),
    .srst_i      (srst_i),
    .in_data_i   (push_data),
    .in_valid_i  (push_valid),
    .in_ready_o  (push_ready),
    .out_data_o  (pop_data),
    .out_valid_o (pop_valid),
    .out_ready_i (!tx_busy)
  );

  // ****************************************
  // serial transmitter
  // ****************************************
  logic [CW-1:0] tx_cnt;
  logic [3:0]    tx_bit;
  logic [9:0]    tx_shift;

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      tx_busy  <= 1'b0;
      tx_cnt   <= '0;
      tx_bit   <= '0;
      tx_shift <= '1;
      ser_tx_o <= 1'b1;
    end else if (!tx_busy) begin
      if (pop_valid) begin
        tx_busy  <= 1'b1;
        tx_shift <= {1'b1, pop_data, 1'b0};
        tx_bit   <= '0;
        tx_cnt   <= '0;
      end
    end else if (tx_cnt != '0) begin
      tx_cnt <= tx_cnt - CW'(1);
    end else if (tx_bit == 4'd10) begin
      tx_busy <= 1'b0;
    end else begin
      ser_tx_o <= tx_shift[0];
      tx_shift <= {1'b1, tx_shift[9:1]};
      tx_bit   <= tx_bit + 4'd1;
      tx_cnt   <= BIT_LAST;
    end
  end
endmodule : serial_gateway
`default_nettype wire

// ### verilog/fieldbus_master_end.sv
`default_nettype none
module fieldbus_master_end #(
  parameter int unsigned IMG_BYTES = gw_pkg::IMG_BYTES
) (
  input  wire logic                         sys_clk_i,
  input  wire logic                         srst_i,
  fieldbus_if.master                        fb,
  input  wire logic                         user_run_i,
  input  wire logic                         user_send_i,
  input  wire logic [IMG_BYTES*8-1:0]       user_out_data_i,
  input  wire logic [gw_pkg::LEN_W-1:0]     user_out_len_i,
  output logic      [IMG_BYTES*8-1:0]       user_in_data_o,
  output logic      [gw_pkg::LEN_W-1:0]     user_in_len_o,
  output logic                              user_in_valid_o,
  output logic                              user_online_o
);
  import gw_pkg::*;
  logic nd_seen;

  // ****************************************
  // output image and send toggle
  // ****************************************
  // image and toggle change on the same edge so the gateway sees a consistent pair
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      fb.out_image          <= '0;
      fb.out_len            <= '0;
      fb.send_output_toggle <= 1'b0;
      fb.op_request         <= 1'b0;
      user_online_o         <= 1'b0;
    end else begin
      fb.op_request <= user_run_i;
      user_online_o <= (fb.slave_state == ST_OP);
      if (user_send_i && fb.slave_state == ST_OP) begin
        fb.out_image          <= user_out_data_i;
        fb.out_len            <= user_out_len_i;
        fb.send_output_toggle <= !fb.send_output_toggle;
      end
    end
  end

  // ****************************************
  // input image capture
  // ****************************************
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      nd_seen         <= 1'b0;
      user_in_data_o  <= '0;
      user_in_len_o   <= '0;
      user_in_valid_o <= 1'b0;
    end else begin
      user_in_valid_o <= 1'b0;
      if (fb.new_data_toggle != nd_seen) begin
        nd_seen         <= fb.new_data_toggle;
        user_in_data_o  <= fb.in_image;
        user_in_len_o   <= fb.in_len;
        user_in_valid_o <= 1'b1;
      end
    end
  end
endmodule : fieldbus_master_end

// ****************************************
// byte fifo of the gateway's send path
// ****************************************
module gw_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = gw_pkg::FIFO_DEPTH
) (
  input  wire logic             sys_clk_i,
  input  wire logic             srst_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  output logic      [WIDTH-1:0] out_data_o,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i
);
  import gw_pkg::*;
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;

  assign in_ready_o  = (count != (AW+1)'(DEPTH));
  assign out_valid_o = (count != '0);
  assign out_data_o  = mem[rd_ptr];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  function automatic logic [AW-1:0] wrap_inc(input logic [AW-1:0] p);
    return (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
  endfunction : wrap_inc

  always_ff @(posedge sys_clk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) wr_ptr <= wrap_inc(wr_ptr);
      if (pop) rd_ptr <= wrap_inc(rd_ptr);
      if (push && !pop) count <= count + (AW+1)'(1);
      else if (pop && !push) count <= count - (AW+1)'(1);
    end
  end
endmodule : gw_fifo
`default_nettype wire

// ### bench/serial_gateway_props.sv
`default_nettype none
module serial_gateway_props #(
  parameter int unsigned IMG_BYTES = gw_pkg::IMG_BYTES
) (
  input wire logic                     sys_clk_i,
  input wire logic                     srst_i,
  input wire logic [IMG_BYTES*8-1:0]   out_image,
  input wire logic [gw_pkg::LEN_W-1:0] out_len,
  input wire logic                     send_output_toggle,
  input wire logic                     op_request,
  input wire logic [IMG_BYTES*8-1:0]   in_image,
  input wire logic [gw_pkg::LEN_W-1:0] in_len,
  input wire logic                     new_data_toggle,
  input wire gw_pkg::slave_state_t     slave_state
);
  import gw_pkg::*;
  // ****************************************
  // interface watch, one clock domain
  // ****************************************
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);
  chk_init_to_preop: assert property (
    slave_state == ST_INIT && op_request |=> slave_state == ST_PREOP)
    else $error("slave left init wrongly");
  chk_preop_to_safeop: assert property (
    slave_state == ST_PREOP && op_request |=> slave_state == ST_SAFEOP)
    else $error("slave left preop wrongly");
  chk_safeop_to_op: assert property (
    slave_state == ST_SAFEOP && op_request |=> slave_state == ST_OP)
    else $error("slave left safeop wrongly");
  chk_drop_to_init: assert property (!op_request |=> slave_state == ST_INIT)
    else $error("slave not back in init");
  chk_nd_only_op: assert property (
    $changed(new_data_toggle) |-> slave_state == ST_OP || $past(slave_state) == ST_OP)
    else $error("input data outside operational");
  // the image must never move on its own, or the master reads a torn telegram
  chk_img_with_nd: assert property (
    $changed(in_len) || $changed(in_image) |-> $changed(new_data_toggle))
    else $error("input image changed without toggle");
  chk_len_bound: assert property (in_len <= IMG_BYTES)
    else $error("input length beyond image");
  chk_send_in_op: assert property (
    $changed(send_output_toggle) |-> slave_state == ST_OP || $past(slave_state) == ST_OP)
    else $error("send toggle outside operational");
  chk_out_steady: assert property (
    $changed(send_output_toggle) |=> $stable(out_image) && $stable(out_len))
    else $error("output image moved under a send");
  chk_nd_once: assert property (
    $changed(new_data_toggle) |=> $stable(new_data_toggle) [*8])
    else $error("new data toggle flipped twice");
endmodule : serial_gateway_props
`default_nettype wire

// ### bench/serial_to_fieldbus_gateway_test.sv
`default_nettype none
`define CHK(got, exp) \
  begin cmp_count++; if ((got) !== (exp)) begin num_errors++; \
  $display("[ERR] %0t got %0h want %0h", $time, (got), (exp)); end end
module serial_to_fieldbus_gateway_test;
  timeunit 1ns;
  timeprecision 1ps;
  import gw_pkg::*;
  // ****************************************
  // harness
  // ****************************************
  localparam int unsigned BC = 16;
  localparam int unsigned IB = IMG_BYTES;
  logic             sys_clk_i, srst_i, ser_rx_i, ser_tx_o, frame_err_o;
  logic [SEL_W-1:0] sel, profile;
  logic             run, send, in_valid, online, nd_exp, sdo_exp;
  logic [IB*8-1:0]  out_data, in_data;
  logic [LEN_W-1:0] out_len, in_len;
  logic [7:0]       long_q[$];
  int               num_errors, cmp_count;
  int               valid_seen, valid_mark, err_seen;
  fieldbus_if #(.IMG_BYTES(IB)) fb_link ();
  serial_gateway #(.BIT_CYCLES(BC), .IMG_BYTES(IB)) u_serial_gateway (.sys_clk_i, .srst_i,
    .fb(fb_link), .ser_rx_i, .ser_tx_o, .device_selector_switch_i(sel), .profile_o(profile),
    .frame_err_o);
  fieldbus_master_end #(.IMG_BYTES(IB)) u_fieldbus_master_end (.sys_clk_i, .srst_i,
    .fb(fb_link), .user_run_i(run), .user_send_i(send), .user_out_data_i(out_data),
    .user_out_len_i(out_len), .user_in_data_o(in_data), .user_in_len_o(in_len),
    .user_in_valid_o(in_valid), .user_online_o(online));
  serial_gateway_props #(.IMG_BYTES(IB)) u_props (.sys_clk_i, .srst_i,
    .out_image(fb_link.out_image), .out_len(fb_link.out_len),
    .send_output_toggle(fb_link.send_output_toggle), .op_request(fb_link.op_request),
    .in_image(fb_link.in_image), .in_len(fb_link.in_len),
    .new_data_toggle(fb_link.new_data_toggle), .slave_state(fb_link.slave_state));
  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  // one-cycle pulses are counted while they stand, so a late look cannot miss one
  always @(posedge sys_clk_i) begin
    if (in_valid === 1'b1) valid_seen <= valid_seen + 1;
    if (frame_err_o === 1'b1) err_seen <= err_seen + 1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask : tick
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : give_verdict
  initial begin
    tick(90000);
    num_errors++;
    give_verdict();
  end
  task automatic do_reset(input logic [SEL_W-1:0] s);
    sel = s; run = 1'b0; srst_i = 1'b1; nd_exp = 1'b0; sdo_exp = 1'b0;
    tick(16);
    srst_i = 1'b0;
    tick(2);
  endtask : do_reset
  task automatic ser_msg(input logic [7:0] q[$]);
    logic [9:0] fr;
    foreach (q[j]) begin
      fr = {1'b1, q[j], 1'b0};
      for (int i = 0; i < 10; i++) begin
        ser_rx_i = fr[i];
        tick(BC);
      end
    end
  endtask : ser_msg
  task automatic ser_get(output logic [7:0] b);
    for (int i = 0; i < 400 && ser_tx_o !== 1'b0; i++) tick(1);
    `CHK(ser_tx_o, 1'b0)
    tick(BC / 2);
    for (int i = 0; i < 8; i++) begin
      tick(BC);
      b[i] = ser_tx_o;
    end
    tick(BC);
    `CHK(ser_tx_o, 1'b1)
  endtask : ser_get
  task automatic wait_valid(input int want);
    tick(20);
    `CHK(valid_seen - valid_mark, want)
    valid_mark = valid_seen;
  endtask : wait_valid
  task automatic go_online();
    run = 1'b1;
    tick(2);
    `CHK(online, 1'b0)
    for (int i = 0; i < 10 && online !== 1'b1; i++) tick(1);
    `CHK(online, 1'b1)
  endtask : go_online
  // framing is checked whole: a stray extra byte would shift every later compare
  task automatic host_send(input logic [LEN_W-1:0] n);
    logic [7:0] b;
    out_len = n; send = 1'b1;
    tick(1);
    send = 1'b0;
    sdo_exp = ~sdo_exp;
    ser_get(b);
    `CHK(b, CHAR_STX)
    for (int k = 0; k < int'(n) && k < int'(IB); k++) begin
      ser_get(b);
      `CHK(b, out_data[8*k +: 8])
    end
    ser_get(b);
    `CHK(b, CHAR_CR)
    ser_get(b);
    `CHK(b, CHAR_LF)
    `CHK(fb_link.send_output_toggle, sdo_exp)
    for (int i = 0; i < 40; i++) begin
      `CHK(ser_tx_o, 1'b1)
      tick(1);
    end
  endtask : host_send
  // ****************************************
  // tests
  // ****************************************
  initial begin
    srst_i = 1'b1; ser_rx_i = 1'b1; send = 1'b0; run = 1'b0;
    out_data = '0; out_len = '0; sel = 4'h3;
    num_errors = 0; cmp_count = 0;
    do_reset(4'h3);
    `CHK(profile, 4'h3)
    sel = SEL_UNIVERSAL;
    tick(4);
    `CHK(profile, 4'h3)
    ser_msg({CHAR_STX, 8'h41, CHAR_CR, CHAR_LF});
    wait_valid(0);
    go_online();
    $display("test startup done");
    ser_msg({CHAR_STX, 8'h41, CHAR_CR, 8'h42, CHAR_CR, CHAR_LF});
    wait_valid(1);
    nd_exp = ~nd_exp;
    `CHK(in_len, 8'h03)
    `CHK(in_data[23:0], 24'h420d41)
    `CHK(fb_link.new_data_toggle, nd_exp)
    ser_msg({8'h5a, CHAR_CR, CHAR_LF});
    wait_valid(0);
    ser_msg({CHAR_STX, 8'h11, CHAR_CR, CHAR_LF, CHAR_STX, 8'h22, 8'h33, CHAR_CR, CHAR_LF});
    wait_valid(2);
    `CHK(fb_link.in_len, 8'h02)
    `CHK(fb_link.in_image[15:0], 16'h3322)
    `CHK(fb_link.new_data_toggle, nd_exp)
    `CHK(err_seen, 0)
    $display("test receive done");
    out_data[23:0] = 24'hff0a31;
    host_send(8'h03);
    host_send(8'h00);
    $display("test send done");
    // twenty asked, sixteen sent: the frame overfills the byte fifo and stalls framing
    out_data = 128'hf0e1d2c3b4a5968778695a4b3c2d1e0f;
    host_send(8'h14);
    $display("test long send done");
    long_q = {CHAR_STX};
    repeat (18) long_q.push_back(8'h55);
    long_q.push_back(CHAR_CR);
    long_q.push_back(CHAR_LF);
    ser_msg(long_q);
    wait_valid(0);
    `CHK(err_seen, 1)
    ser_msg({CHAR_STX, 8'h77, CHAR_CR, CHAR_LF});
    wait_valid(1);
    `CHK(in_len, 8'h01)
    `CHK(in_data[7:0], 8'h77)
    run = 1'b0;
    tick(4);
    `CHK(online, 1'b0)
    $display("test overlong done");
    do_reset(SEL_UNIVERSAL);
    `CHK(profile, SEL_UNIVERSAL)
    go_online();
    ser_msg({8'h5a, CHAR_CR, CHAR_LF});
    wait_valid(1);
    `CHK(in_data[7:0], 8'h5a)
    `CHK(in_len, 8'h01)
    ser_msg({8'h6b, CHAR_CR, CHAR_LF});
    wait_valid(1);
    `CHK(in_data[7:0], 8'h6b)
    `CHK(in_len, 8'h01)
    $display("test universal done");
    give_verdict();
  end
endmodule : serial_to_fieldbus_gateway_test
`default_nettype wire
